// file: rxd_pkg.sv
// Shared constants for the receiver-detect configuration block.
// Assumes a 10 MHz core clock and 8-bit register addresses and data.
package rxd_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned PROBE_PERIOD_MS = 12;
    localparam int unsigned POLL_WINDOW_MS = 600;
    localparam int unsigned PROBE_PERIOD_TICKS =
        PROBE_PERIOD_MS * 1000 / TICK_US;
    localparam int unsigned POLL_WINDOW_TICKS =
        POLL_WINDOW_MS * 1000 / TICK_US;
    localparam int unsigned NUM_CHAN = 2;
    localparam int unsigned SYNC_PINS = 5;

    localparam logic [7:0] OFS_GLOBAL_CTRL = 8'h06;
    localparam logic [7:0] OFS_STATUS = 8'h07;
    localparam logic [7:0] OFS_DETECT_OWNER = 8'h08;
    localparam logic [7:0] OFS_CHAN_A_MODE = 8'h0E;
    localparam logic [7:0] OFS_CHAN_B_MODE = 8'h15;

    localparam logic [7:0] VAL_COMMIT = 8'h18;
    localparam logic [7:0] VAL_OWNER_REGS = 8'h08;
    localparam logic [7:0] VAL_MODE_LIMITED = 8'h04;
    localparam logic [7:0] VAL_MODE_UNLIMITED = 8'h08;

    localparam logic [7:0] RST_GLOBAL_CTRL = 8'h00;
    localparam logic [7:0] RST_DETECT_OWNER = 8'h00;
    localparam logic [7:0] RST_CHAN_MODE = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // Synchronised pin vector positions
    localparam int unsigned PIN_STRAP = 0;
    localparam int unsigned PIN_SER_EN = 1;
    localparam int unsigned PIN_POWER_DOWN = 2;
    localparam int unsigned PIN_SENSE_A = 3;
    // Power-down reads as asserted until the synchroniser has filled
    localparam logic [4:0] RST_PINS = 5'h04;

    typedef enum logic [1:0] {
        RXD_IDLE,
        RXD_POLL,
        RXD_FOUND,
        RXD_EXPIRED
    } rxd_state_t;
endpackage

// file: rxd_chan_if.sv
// Carrier between the control top and one channel detect engine.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface rxd_chan_if;
    logic tick;
    logic start;
    logic run;
    logic limited;
    logic rx_present;
    logic probe;
    logic term;
    logic expired;
    modport ctrl (
        output tick, start, run, limited, rx_present,
        input probe, term, expired
    );
    modport chan (
        input tick, start, run, limited, rx_present,
        output probe, term, expired
    );
endinterface
`default_nettype wire

// file: rxd_chan.sv
// One channel's automatic receiver-detect engine.
// Assumes a one-cycle millisecond tick and a synchronised receiver sense.
`timescale 1ns/1ps
`default_nettype none
module rxd_chan #(
    parameter int unsigned PERIOD_TICKS = rxd_pkg::PROBE_PERIOD_TICKS,
    parameter int unsigned WINDOW_TICKS = rxd_pkg::POLL_WINDOW_TICKS
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    rxd_chan_if.chan ch
);
    rxd_pkg::rxd_state_t state_reg;
    logic [15:0] period_reg;
    logic [15:0] window_reg;

    assign ch.term = (state_reg == rxd_pkg::RXD_FOUND);
    assign ch.expired = (state_reg == rxd_pkg::RXD_EXPIRED);

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !ch.run) begin
            state_reg <= rxd_pkg::RXD_IDLE;
            period_reg <= 16'h0000;
            window_reg <= 16'h0000;
            ch.probe <= 1'b0;
        end else if (ch.start) begin
            // First probe goes out at once, then on the period
            state_reg <= rxd_pkg::RXD_POLL;
            period_reg <= 16'h0000;
            window_reg <= 16'h0000;
            ch.probe <= 1'b1;
        end else begin
            ch.probe <= 1'b0;
            case (state_reg)
                rxd_pkg::RXD_POLL: begin
                    if (ch.probe && ch.rx_present) begin
                        // Found wins over a window ending in the same cycle
                        state_reg <= rxd_pkg::RXD_FOUND;
                    end else if (ch.tick) begin
                        if (period_reg == 16'(PERIOD_TICKS - 1)) begin
                            period_reg <= 16'h0000;
                            ch.probe <= 1'b1;
                        end else begin
                            period_reg <= period_reg + 16'h0001;
                        end
                        if (ch.limited &&
                            window_reg == 16'(WINDOW_TICKS - 1)) begin
                            state_reg <= rxd_pkg::RXD_EXPIRED;
                            ch.probe <= 1'b0;
                        end else begin
                            window_reg <= window_reg + 16'h0001;
                        end
                    end
                end
                rxd_pkg::RXD_FOUND: state_reg <= rxd_pkg::RXD_FOUND;
                rxd_pkg::RXD_EXPIRED: begin
                    state_reg <= rxd_pkg::RXD_EXPIRED;
                end
                default: state_reg <= rxd_pkg::RXD_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: rxd_top.sv
// Receiver-detect configuration and control for a one-lane redriver.
// Assumes an upstream serial front end that turns bus frames into
// single-cycle register reads and writes on the core clock.
//
// Summary of operation
// - Channel A mode 0x04 at offset 0x0E probes every 12 ms and stops after 600 ms.
// - Mode 0x08 probes every 12 ms with no limit until a receiver is found.
// - Channel B mode at offset 0x15 takes the same two choices with the same behaviour.
// - Except with the strap high under pin control, input termination stays high impedance until detection, then switches to 50 ohms.
// - Writing 0x18 to offset 0x06 is what applies the earlier detect settings to the channels.
`timescale 1ns/1ps
`default_nettype none
module rxd_top #(
    parameter int unsigned TICK_CYCLES = rxd_pkg::TICK_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic receiver_detect_pin_i,
    input wire logic serial_config_enable_pin_i,
    input wire logic power_down_pin_i,
    input wire logic [1:0] rx_sense_i,
    input wire logic eeprom_load_done_i,
    output logic load_complete_n_o,
    output logic [1:0] probe_o,
    output logic [1:0] term_50_o,
    output logic [1:0] detect_expired_o
);
    localparam int unsigned NCH = rxd_pkg::NUM_CHAN;
    localparam int unsigned NSP = rxd_pkg::SYNC_PINS;

    logic [7:0] global_ctrl_reg;
    logic [7:0] owner_reg;
    logic [7:0] mode_reg [NCH];
    logic [7:0] owner_applied_reg;
    logic [7:0] mode_applied_reg [NCH];
    logic commit_reg;
    logic [NSP-1:0] pins_raw;
    logic [NSP-1:0] sync1_reg;
    logic [NSP-1:0] sync2_reg;
    logic [NSP-1:0] sync3_reg;
    logic [NSP-1:0] pins_reg;
    logic [15:0] tick_cnt_reg;
    logic tick_reg;
    logic run_reg;
    logic run_prev_reg;
    logic regs_own;
    logic strap_bypass;
    logic [NCH-1:0] ch_probe;
    logic [NCH-1:0] ch_term;
    logic [NCH-1:0] ch_expired;

    rxd_chan_if chif [NCH] ();

    assign pins_raw = {rx_sense_i, power_down_pin_i,
                       serial_config_enable_pin_i, receiver_detect_pin_i};

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            // Avoids a false power-down release right after reset
            sync1_reg <= rxd_pkg::RST_PINS;
            sync2_reg <= rxd_pkg::RST_PINS;
            sync3_reg <= rxd_pkg::RST_PINS;
            pins_reg <= rxd_pkg::RST_PINS;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < NSP; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    pins_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    // Millisecond enable for the probe period and window counters
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tick_cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 16'h0000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    // Register writes
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            global_ctrl_reg <= rxd_pkg::RST_GLOBAL_CTRL;
            owner_reg <= rxd_pkg::RST_DETECT_OWNER;
            mode_reg[0] <= rxd_pkg::RST_CHAN_MODE;
            mode_reg[1] <= rxd_pkg::RST_CHAN_MODE;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                rxd_pkg::OFS_GLOBAL_CTRL: global_ctrl_reg <= reg_wdata_i;
                rxd_pkg::OFS_DETECT_OWNER: owner_reg <= reg_wdata_i;
                rxd_pkg::OFS_CHAN_A_MODE: mode_reg[0] <= reg_wdata_i;
                rxd_pkg::OFS_CHAN_B_MODE: mode_reg[1] <= reg_wdata_i;
                default: owner_reg <= owner_reg;
            endcase
        end
    end

    // Settings reach the channels only on the commit write
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            owner_applied_reg <= rxd_pkg::RST_DETECT_OWNER;
            mode_applied_reg[0] <= rxd_pkg::RST_CHAN_MODE;
            mode_applied_reg[1] <= rxd_pkg::RST_CHAN_MODE;
            commit_reg <= 1'b0;
        end else begin
            commit_reg <= 1'b0;
            if (reg_wr_i && reg_addr_i == rxd_pkg::OFS_GLOBAL_CTRL &&
                reg_wdata_i == rxd_pkg::VAL_COMMIT) begin
                owner_applied_reg <= owner_reg;
                mode_applied_reg[0] <= mode_reg[0];
                mode_applied_reg[1] <= mode_reg[1];
                commit_reg <= 1'b1;
            end
        end
    end

    // Reads: one cycle later, unmapped offsets answer zero
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= rxd_pkg::RDATA_UNMAPPED;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    rxd_pkg::OFS_GLOBAL_CTRL: reg_rdata_o <= global_ctrl_reg;
                    rxd_pkg::OFS_STATUS:
                        reg_rdata_o <= {2'b00, !run_reg, regs_own,
                                        ch_expired, ch_term};
                    rxd_pkg::OFS_DETECT_OWNER: reg_rdata_o <= owner_reg;
                    rxd_pkg::OFS_CHAN_A_MODE: reg_rdata_o <= mode_reg[0];
                    rxd_pkg::OFS_CHAN_B_MODE: reg_rdata_o <= mode_reg[1];
                    default: reg_rdata_o <= rxd_pkg::RDATA_UNMAPPED;
                endcase
            end
        end
    end

    assign regs_own = (owner_applied_reg == rxd_pkg::VAL_OWNER_REGS);
    // Strap high under pin control: no detection, termination on at once
    assign strap_bypass = !regs_own && pins_reg[rxd_pkg::PIN_STRAP];

    // Power-down holds the engines idle; release restarts detection
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            run_reg <= 1'b0;
            run_prev_reg <= 1'b0;
        end else begin
            run_reg <= !pins_reg[rxd_pkg::PIN_POWER_DOWN];
            run_prev_reg <= run_reg;
        end
    end

    // Flag is low only while the EEPROM load has finished
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            load_complete_n_o <= 1'b1;
        end else begin
            load_complete_n_o <= !(eeprom_load_done_i &&
                                   !pins_reg[rxd_pkg::PIN_SER_EN]);
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_chan
        logic mode_ok;
        assign mode_ok = (mode_applied_reg[c] == rxd_pkg::VAL_MODE_LIMITED) ||
                         (mode_applied_reg[c] == rxd_pkg::VAL_MODE_UNLIMITED);
        assign chif[c].tick = tick_reg;
        // Strap control polls without limit from power-up
        assign chif[c].run = run_reg && !strap_bypass &&
                             (!regs_own || mode_ok);
        assign chif[c].start = (run_reg && !run_prev_reg) || commit_reg;
        assign chif[c].limited = regs_own &&
            (mode_applied_reg[c] == rxd_pkg::VAL_MODE_LIMITED);
        assign chif[c].rx_present = pins_reg[rxd_pkg::PIN_SENSE_A + c];
        assign ch_probe[c] = chif[c].probe;
        assign ch_term[c] = chif[c].term;
        assign ch_expired[c] = chif[c].expired;

        rxd_chan #(
            .PERIOD_TICKS(rxd_pkg::PROBE_PERIOD_TICKS),
            .WINDOW_TICKS(rxd_pkg::POLL_WINDOW_TICKS)
        ) u_chan (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .ch(chif[c])
        );
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            probe_o <= 2'b00;
            term_50_o <= 2'b00;
            detect_expired_o <= 2'b00;
        end else begin
            probe_o <= ch_probe;
            term_50_o <= strap_bypass && run_reg ? 2'b11 : ch_term;
            detect_expired_o <= ch_expired;
        end
    end
endmodule
`default_nettype wire

// file: rxd_top_props.sv
// Port-level checker for the receiver-detect control top.
// Assumes it is bound into rxd_top with its tick parameter.
`timescale 1ns/1ps
`default_nettype none
module rxd_top_props #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic serial_config_enable_pin_i,
    input wire logic power_down_pin_i,
    input wire logic eeprom_load_done_i,
    input wire logic load_complete_n_o,
    input wire logic [1:0] probe_o,
    input wire logic [1:0] term_50_o,
    input wire logic [1:0] detect_expired_o
);
    localparam int unsigned PER = 12 * TICK_CYCLES;
    logic [2:0] quiet_reg;
    logic [1:0] seen_reg;
    int unsigned gap_reg;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Writes and power-down may legally restart or stop a channel
    always_ff @(posedge core_clk_i) begin
        if (rst_i || reg_wr_i || power_down_pin_i) quiet_reg <= 3'h0;
        else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
    end
    always_ff @(posedge core_clk_i) begin
        // Counts probes since a restart, saturating at two
        if (rst_i || reg_wr_i || power_down_pin_i) seen_reg <= 2'h0;
        else if (probe_o[0] && seen_reg != 2'h2)
            seen_reg <= seen_reg + 2'h1;
    end
    always_ff @(posedge core_clk_i) begin
        if (probe_o[0]) gap_reg <= 1;
        else gap_reg <= gap_reg + 1;
    end
    sequence pd_held;
        power_down_pin_i [*8];
    endsequence
    sequence eeprom_ready;
        (eeprom_load_done_i && !serial_config_enable_pin_i) [*7];
    endsequence
    AST_RVALID_NEXT: assert property (
        reg_rvalid_o == $past(reg_rd_i))
        else $error("read answer timing wrong");
    AST_UNMAPPED_ZERO: assert property (
        reg_rd_i && !(reg_addr_i inside {8'h06, 8'h07, 8'h08, 8'h0E, 8'h15})
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_PROBE_PULSE: assert property (
        probe_o != 2'b00 |=> (probe_o & $past(probe_o)) == 2'b00)
        else $error("probe longer than one cycle");
    // First gap runs from the start, not from a tick, so it can be shorter by less than a tick
    AST_PROBE_FIRST: assert property (
        probe_o[0] && seen_reg == 2'h1 |->
        gap_reg > PER - TICK_CYCLES && gap_reg <= PER)
        else $error("first probe spacing wrong");
    AST_PROBE_PERIOD: assert property (
        probe_o[0] && seen_reg == 2'h2 |-> gap_reg == PER)
        else $error("probe spacing wrong");
    AST_TERM_HOLD: assert property (
        term_50_o[0] && quiet_reg == 3'h7 |=> term_50_o[0])
        else $error("termination dropped");
    AST_EXPIRED_IDLE: assert property (
        detect_expired_o[0] && quiet_reg == 3'h7
        |-> ##2 (!probe_o[0] && !term_50_o[0]))
        else $error("expired channel still active");
    AST_PD_IDLE: assert property (
        pd_held |-> probe_o == 2'b00 && term_50_o == 2'b00)
        else $error("activity in power-down");
    AST_LOAD_DONE: assert property (
        eeprom_ready |-> !load_complete_n_o)
        else $error("load flag not low");
    AST_LOAD_IDLE: assert property (
        !eeprom_load_done_i |=> load_complete_n_o)
        else $error("load flag low early");
endmodule
bind rxd_top rxd_top_props #(.TICK_CYCLES(TICK_CYCLES)) u_rxd_top_props (
    .core_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_rdata_o,
    .reg_rvalid_o, .serial_config_enable_pin_i, .power_down_pin_i,
    .eeprom_load_done_i, .load_complete_n_o, .probe_o, .term_50_o,
    .detect_expired_o
);
`default_nettype wire

// file: rxd_far_end.sv
// Far-end receiver model: counts probes, then shows presence.
// Assumes probes are one-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module rxd_far_end (
    input wire logic core_clk_i,
    input wire logic clr_i,
    input wire logic [1:0] probe_i,
    input wire logic [1:0] plug_i,
    input wire logic [7:0] after_a_i,
    input wire logic [7:0] after_b_i,
    output logic [1:0] rx_sense_o
);
    logic [7:0] cnt_a;
    logic [7:0] cnt_b;
    // Presence is a level, so it must lead the probe that finds it
    always @(posedge core_clk_i) begin
        if (clr_i) begin
            cnt_a <= 8'h00;
            cnt_b <= 8'h00;
        end else begin
            cnt_a <= cnt_a + {7'h00, probe_i[0]};
            cnt_b <= cnt_b + {7'h00, probe_i[1]};
        end
    end
    assign rx_sense_o[0] = plug_i[0] && (cnt_a >= after_a_i);
    assign rx_sense_o[1] = plug_i[1] && (cnt_b >= after_b_i);
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the receiver-detect control top.
// Assumes the design, its checker and the far-end model compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin \
    comparisons++; \
    if ((e) !== (s)) begin \
        n_errors++; \
        $display("MISMATCH %s exp %0h got %0h", n, e, s); \
    end \
end
module tb_top;
    logic clk = 0, rst = 1, wr = 0, rd = 0, sen = 1, pd = 1, strap = 0;
    logic done = 0, clr = 1, rvalid, ld_n;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ev, rnd = 8'h61;
    logic [7:0] aft_a = 8'h00, aft_b = 8'h00;
    logic [1:0] plug = 2'b00, sense, probe, term, expd;
    logic [7:0] exp_q[$];
    logic [7:0] regs[4] = '{8'h06, 8'h08, 8'h0E, 8'h15};
    int n_errors = 0, comparisons = 0, pa = 0, pb = 0, i;
    rxd_top #(.TICK_CYCLES(10)) u_rxd_top (
        .core_clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .receiver_detect_pin_i(strap),
        .serial_config_enable_pin_i(sen), .power_down_pin_i(pd),
        .rx_sense_i(sense), .eeprom_load_done_i(done),
        .load_complete_n_o(ld_n), .probe_o(probe), .term_50_o(term),
        .detect_expired_o(expd)
    );
    rxd_far_end u_rxd_far_end (
        .core_clk_i(clk), .clr_i(clr), .probe_i(probe), .plug_i(plug),
        .after_a_i(aft_a), .after_b_i(aft_b), .rx_sense_o(sense)
    );
    initial begin
        forever #50 clk = ~clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic close_out();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Bounded wait on termination (s=0) or expiry (s=1) of channel b
    task automatic wait_hi(input int s, input int b, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            @(negedge clk);
            if ((s == 0 ? term[b] : expd[b]) === 1'b1) return;
        end
        n_errors++;
        $display("MISMATCH wait_%0d_%0d exp 1 got 0", s, b);
        close_out();
    endtask
    always @(negedge clk) begin
        if (probe[0] === 1'b1) pa++;
        if (probe[1] === 1'b1) pb++;
        if (rvalid === 1'b1) begin
            ev = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
            `CHK("rdata", ev, rdata)
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        clr <= 1'b0;
        for (i = 0; i < 4; i++) rreg(regs[i], 8'h00);
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            wreg(8'h0E, rnd);
            rreg(8'h0E, rnd);
        end
        wreg(8'h01, 8'h5A);
        wreg(8'h07, 8'hFF);
        rreg(8'h01, 8'h00);
        rreg(8'h07, 8'h20);
        // Full sequence while still held in power-down
        wreg(8'h08, 8'h08);
        wreg(8'h0E, 8'h04);
        wreg(8'h15, 8'h08);
        rreg(8'h15, 8'h08);
        plug <= 2'b10;
        aft_b <= 8'h02;
        wreg(8'h06, 8'h18);
        repeat (20) @(posedge clk);
        `CHK("probes_pd", 0, pa + pb)
        pd <= 1'b0;
        wait_hi(0, 1, 400);
        `CHK("probes_b", 3, pb)
        wait_hi(1, 0, 6200);
        `CHK("probes_a", 50, pa)
        `CHK("term", 2'b10, term)
        `CHK("expired", 2'b01, expd)
        rreg(8'h07, 8'h16);
        // Recommit with channel A unlimited; receiver after one probe
        clr <= 1'b1;
        wreg(8'h0E, 8'h08);
        clr <= 1'b0;
        aft_a <= 8'h01;
        plug <= 2'b11;
        pa = 0;
        wreg(8'h06, 8'h18);
        wait_hi(0, 0, 400);
        `CHK("probes_a2", 2, pa)
        `CHK("expired2", 2'b00, expd)
        wreg(8'h15, 8'h05);
        wreg(8'h06, 8'h18);
        // Let a probe already launched before the commit drain out
        repeat (4) @(negedge clk);
        pb = 0;
        repeat (300) @(negedge clk);
        `CHK("probes_bad", 0, pb)
        `CHK("term_bad", 1'b0, term[1])
        // Second reset: strap polling with loader finished
        @(posedge clk);
        rst <= 1'b1;
        sen <= 1'b0;
        done <= 1'b1;
        clr <= 1'b1;
        pd <= 1'b1;
        rnd = lfsr(rnd);
        aft_a <= {6'h00, rnd[1:0]} + 8'h01;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        clr <= 1'b0;
        repeat (10) @(negedge clk);
        `CHK("load_n", 1'b0, ld_n)
        pa = 0;
        @(posedge clk);
        pd <= 1'b0;
        wait_hi(0, 0, 700);
        `CHK("probes_strap", int'(aft_a) + 1, pa)
        @(posedge clk);
        pd <= 1'b1;
        repeat (10) @(negedge clk);
        `CHK("term_pd", 2'b00, term)
        // Strap tied high under pin control: no probing, termination on
        @(posedge clk);
        strap <= 1'b1;
        pa = 0;
        pb = 0;
        repeat (10) @(posedge clk);
        pd <= 1'b0;
        wait_hi(0, 1, 40);
        repeat (150) @(negedge clk);
        `CHK("probes_tied", 0, pa + pb)
        `CHK("term_tied", 2'b11, term)
        close_out();
    end
endmodule
`default_nettype wire
